// file: src/tag_alarm_gen.sv
// Transmit alarm generator for one DS3/E3 framer channel
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tag_alarm_gen (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_bit_en,
  input wire logic tx_data,
  input wire tag_pkg::tag_pos_t tx_pos,
  input wire logic tx_frame_start,
  input wire logic [2:0] tx_subframe,
  input wire logic [1:0] tx_grp_idx,
  input wire logic ext_overhead_in,
  input wire logic signal_loss_flag,
  input wire logic frame_loss_flag,
  input wire logic rx_frame_bit_error,
  input wire logic rx_path_parity_error,
  input wire logic rx_bip8_error,
  output logic line_pos_out,
  output logic line_neg_out
);
  import tag_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [TAG_CTRL_W-1:0] ctrl_ff;
  logic [TAG_CTRL_W-1:0] nxt_ctrl;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic ext_s1_ff;
  logic ext_s2_ff;
  tag_alm_e ds3_alarm_ff;
  tag_alm_e nxt_ds3_alarm;
  logic febe_pend_ff;
  logic febe_send_ff;
  logic rei_pend_ff;
  logic par_acc_ff;
  logic par_ff;
  logic line_pos_ff;
  logic line_neg_ff;
  logic nxt_line_pos;
  logic e3_remote_bit;

  tag_pat_if pat ();

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire [1:0] mode = ctrl_ff[TAG_MODE_LSB +: 2];
  wire [1:0] alarm_select = ctrl_ff[TAG_SEL_LSB +: 2];
  wire alarm_select_hi = alarm_select[1];
  wire alarm_select_lo = alarm_select[0];
  wire force_line_zero = ctrl_ff[TAG_LZ_BIT];
  wire ext_far_end_error_src = ctrl_ff[TAG_EXTFE_BIT];
  wire auto_remote_alarm_en = ctrl_ff[TAG_AUTORA_BIT];
  wire ext_remote_alarm_src = ctrl_ff[TAG_EXTRA_BIT];
  wire all_oh_with_data = ctrl_ff[TAG_ALLOH_BIT];
  wire [2:0] far_end_error_pattern = ctrl_ff[TAG_PAT_LSB +: 3];

  wire is_ds3 = (mode == TAG_MODE_M13) || (mode == TAG_MODE_CBIT);
  wire is_cbit = (mode == TAG_MODE_CBIT);
  wire is_g751 = (mode == TAG_MODE_G751);
  wire is_g832 = (mode == TAG_MODE_G832);
  wire step = ce && tx_bit_en;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  function automatic logic [TAG_CTRL_W-1:0] tag_wr_merge(
    input logic [TAG_CTRL_W-1:0] old_v,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [TAG_CTRL_W-1:0] res;
    res = old_v;
    if (sel[0])
      res[7:0] = dat[7:0];
    if (sel[1])
      res[TAG_CTRL_W-1:8] = dat[TAG_CTRL_W-1:8];
    return res;
  endfunction : tag_wr_merge

  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire hit_ctrl = (wb_adr_i == TAG_CTRL_OFS);
  wire hit_stat = (wb_adr_i == TAG_STAT_OFS);
  wire ctrl_wr = wb_req && wb_we_i && hit_ctrl;

  assign nxt_ctrl = ctrl_wr ? tag_wr_merge(ctrl_ff, wb_dat_i, wb_sel_i) : ctrl_ff;

  wire [31:0] stat_word = {23'h0, frame_loss_flag, signal_loss_flag, e3_remote_bit,
                           rei_pend_ff, febe_pend_ff, ds3_alarm_ff};
  assign nxt_rdat = hit_ctrl ? {20'h0, ctrl_ff} : (hit_stat ? stat_word : 32'h0);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_ff <= TAG_CTRL_RST;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else if (ce)
    begin
      ctrl_ff <= nxt_ctrl;
      ack_ff <= wb_req;
      rdat_ff <= wb_req ? nxt_rdat : rdat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ----------------------------------------
  // External overhead pin synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
    end
    else if (ce)
    begin
      ext_s1_ff <= ext_overhead_in;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  // ----------------------------------------
  // DS3 alarm state, frame aligned
  // ----------------------------------------
  function automatic tag_alm_e tag_sel_dec(input logic [1:0] sel);
    tag_alm_e res;
    res = TAG_ALM_NORMAL;
    unique case (sel)
      2'h0: res = TAG_ALM_NORMAL;
      2'h1: res = TAG_ALM_YELLOW;
      2'h2: res = TAG_ALM_IDLE;
      2'h3: res = TAG_ALM_AIS;
    endcase
    return res;
  endfunction : tag_sel_dec

  assign nxt_ds3_alarm = (step && tx_frame_start) ? tag_sel_dec(alarm_select) : ds3_alarm_ff;

  always_ff @(posedge mclk)
  begin
    if (srst)
      ds3_alarm_ff <= TAG_ALM_NORMAL;
    else if (ce)
      ds3_alarm_ff <= nxt_ds3_alarm;
  end

  // ----------------------------------------
  // Payload pattern generator
  // ----------------------------------------
  assign pat.bit_en = tx_bit_en;
  assign pat.oh_bit = (tx_pos != TAG_POS_PAY);

  tag_pat_gen u_pat (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .pat(pat)
  );

  // ----------------------------------------
  // Far-end block error and remote error
  // ----------------------------------------
  wire febe_slot = is_cbit && (tx_pos == TAG_POS_C) && (tx_subframe == TAG_SF_FEBE);
  wire febe_take = step && febe_slot && (tx_grp_idx == 2'h0);
  wire febe_err = rx_frame_bit_error || rx_path_parity_error;
  wire febe_now = (tx_grp_idx == 2'h0) ? febe_pend_ff : febe_send_ff;
  wire febe_bit = febe_now ? far_end_error_pattern[2'h2 - tx_grp_idx] : 1'b1;
  wire rei_take = step && is_g832 && (tx_pos == TAG_POS_REI);
  wire rei_bit = rei_pend_ff && !frame_loss_flag;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      febe_pend_ff <= 1'b0;
      febe_send_ff <= 1'b0;
      rei_pend_ff <= 1'b0;
    end
    else if (ce)
    begin
      febe_pend_ff <= febe_err || (febe_pend_ff && !febe_take);
      febe_send_ff <= febe_take ? febe_pend_ff : febe_send_ff;
      rei_pend_ff <= rx_bip8_error || (rei_pend_ff && !rei_take);
    end
  end

  // ----------------------------------------
  // E3 remote alarm or defect bit
  // ----------------------------------------
  wire e3_auto_bit = signal_loss_flag || frame_loss_flag;
  wire e3_src_bit = all_oh_with_data ? tx_data :
                    auto_remote_alarm_en ? e3_auto_bit :
                    ext_remote_alarm_src ? ext_s2_ff : 1'b0;
  assign e3_remote_bit = alarm_select_hi || e3_src_bit;
  wire e3_remote_slot = (is_g751 && (tx_pos == TAG_POS_ABIT)) ||
                        (is_g832 && (tx_pos == TAG_POS_RDI));

  // ----------------------------------------
  // DS3 output bit selection
  // ----------------------------------------
  wire ds3_c_norm = (febe_slot && !ext_far_end_error_src) ? febe_bit : tx_data;
  wire ds3_ais_bit = (tx_pos == TAG_POS_PAY) ? pat.ais_bit :
                     (tx_pos == TAG_POS_P) ? par_ff :
                     (tx_pos == TAG_POS_X) ? 1'b1 :
                     (tx_pos == TAG_POS_C) ? 1'b0 : tx_data;
  wire ds3_idle_bit = (tx_pos == TAG_POS_PAY) ? pat.idle_bit :
                      (tx_pos == TAG_POS_P) ? par_ff :
                      (tx_pos == TAG_POS_X) ? 1'b1 :
                      (tx_pos != TAG_POS_C) ? tx_data :
                      (tx_subframe == TAG_SF_IDLE_C) ? 1'b0 : ds3_c_norm;
  wire ds3_norm_bit = (tx_pos == TAG_POS_C) ? ds3_c_norm :
                      (tx_pos == TAG_POS_X && ds3_alarm_ff == TAG_ALM_YELLOW) ? 1'b0 :
                      tx_data;
  wire ds3_bit = (ds3_alarm_ff == TAG_ALM_AIS) ? ds3_ais_bit :
                 (ds3_alarm_ff == TAG_ALM_IDLE) ? ds3_idle_bit : ds3_norm_bit;

  // ----------------------------------------
  // E3 output bit selection
  // ----------------------------------------
  wire e3_rei_src = (ext_far_end_error_src || all_oh_with_data) ? tx_data : rei_bit;
  wire e3_bit = alarm_select_lo ? 1'b1 :
                e3_remote_slot ? e3_remote_bit :
                (is_g832 && tx_pos == TAG_POS_REI) ? e3_rei_src : tx_data;

  // ----------------------------------------
  // Line output and DS3 parity tracking
  // ----------------------------------------
  assign nxt_line_pos = force_line_zero ? 1'b0 : (is_ds3 ? ds3_bit : e3_bit);
  wire pay_bit = (tx_pos == TAG_POS_PAY) && nxt_line_pos;

  // Stream is consumed at its own pace, never stalled
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      line_pos_ff <= 1'b0;
      line_neg_ff <= 1'b0;
      par_acc_ff <= 1'b0;
      par_ff <= 1'b0;
    end
    else if (step)
    begin
      line_pos_ff <= nxt_line_pos;
      line_neg_ff <= 1'b0;
      par_acc_ff <= tx_frame_start ? pay_bit : (par_acc_ff ^ pay_bit);
      par_ff <= tx_frame_start ? par_acc_ff : par_ff;
    end
  end

  assign line_pos_out = line_pos_ff;
  assign line_neg_out = line_neg_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_line_zero: assert property (@(posedge mclk) disable iff (srst)
    step && force_line_zero |=> !line_pos_out && !line_neg_out)
    else $error("line not zero while forced");

  a_alarm_latch: assert property (@(posedge mclk) disable iff (srst)
    step && tx_frame_start |=> ds3_alarm_ff == tag_sel_dec($past(alarm_select)))
    else $error("alarm state not taken at frame start");

  a_alarm_hold: assert property (@(posedge mclk) disable iff (srst)
    !(step && tx_frame_start) |=> $stable(ds3_alarm_ff))
    else $error("alarm state changed mid frame");

  a_yellow_x: assert property (@(posedge mclk) disable iff (srst)
    step && is_ds3 && ds3_alarm_ff == TAG_ALM_YELLOW && tx_pos == TAG_POS_X && !force_line_zero
    |=> !line_pos_out)
    else $error("yellow X bit not zero");

  a_ais_cbit: assert property (@(posedge mclk) disable iff (srst)
    step && is_ds3 && ds3_alarm_ff == TAG_ALM_AIS && tx_pos == TAG_POS_C |=> !line_pos_out)
    else $error("AIS C bit not zero");

  a_idle_c3: assert property (@(posedge mclk) disable iff (srst)
    step && is_ds3 && ds3_alarm_ff == TAG_ALM_IDLE && tx_pos == TAG_POS_C
    && tx_subframe == TAG_SF_IDLE_C |=> !line_pos_out)
    else $error("IDLE subframe 3 C bit not zero");

  a_febe_pat: assert property (@(posedge mclk) disable iff (srst)
    step && febe_slot && tx_grp_idx == 2'h0 && !ext_far_end_error_src && !force_line_zero
    && ds3_alarm_ff == TAG_ALM_NORMAL |=> line_pos_out == ($past(febe_pend_ff)
    ? $past(far_end_error_pattern[2]) : 1'b1))
    else $error("far-end error bit wrong");

  a_e3_ais: assert property (@(posedge mclk) disable iff (srst)
    step && !is_ds3 && alarm_select_lo && !force_line_zero |=> line_pos_out)
    else $error("E3 AIS not all ones");

  a_remote_force: assert property (@(posedge mclk) disable iff (srst)
    step && e3_remote_slot && alarm_select_hi && !force_line_zero |=> line_pos_out)
    else $error("remote alarm not forced");

  a_rei_oof: assert property (@(posedge mclk) disable iff (srst)
    step && is_g832 && tx_pos == TAG_POS_REI && frame_loss_flag && !alarm_select_lo
    && !ext_far_end_error_src && !all_oh_with_data |=> !line_pos_out)
    else $error("remote error sent during frame loss");
endmodule : tag_alarm_gen
`default_nettype wire

// file: src/tag_pkg.sv
// Package: constants and types of the transmit alarm generator
package tag_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] TAG_CTRL_OFS = 8'h00;
  localparam logic [7:0] TAG_STAT_OFS = 8'h04;
  localparam logic [11:0] TAG_CTRL_RST = 12'h000;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int TAG_MODE_LSB = 0;
  localparam int TAG_SEL_LSB = 2;
  localparam int TAG_LZ_BIT = 4;
  localparam int TAG_EXTFE_BIT = 5;
  localparam int TAG_AUTORA_BIT = 6;
  localparam int TAG_EXTRA_BIT = 7;
  localparam int TAG_ALLOH_BIT = 8;
  localparam int TAG_PAT_LSB = 9;
  localparam int TAG_CTRL_W = 12;
  // ----------------------------------------
  // Line modes
  // ----------------------------------------
  localparam logic [1:0] TAG_MODE_M13 = 2'h0;
  localparam logic [1:0] TAG_MODE_CBIT = 2'h1;
  localparam logic [1:0] TAG_MODE_G751 = 2'h2;
  localparam logic [1:0] TAG_MODE_G832 = 2'h3;
  // ----------------------------------------
  // Bit position codes of the input stream
  // ----------------------------------------
  typedef logic [3:0] tag_pos_t;
  localparam tag_pos_t TAG_POS_PAY = 4'h0;
  localparam tag_pos_t TAG_POS_F = 4'h1;
  localparam tag_pos_t TAG_POS_M = 4'h2;
  localparam tag_pos_t TAG_POS_P = 4'h3;
  localparam tag_pos_t TAG_POS_X = 4'h4;
  localparam tag_pos_t TAG_POS_C = 4'h5;
  localparam tag_pos_t TAG_POS_ABIT = 4'h6;
  localparam tag_pos_t TAG_POS_RDI = 4'h7;
  localparam tag_pos_t TAG_POS_REI = 4'h8;
  localparam tag_pos_t TAG_POS_OH = 4'h9;
  localparam logic [2:0] TAG_SF_IDLE_C = 3'h3;
  localparam logic [2:0] TAG_SF_FEBE = 3'h4;
  // ----------------------------------------
  // DS3 alarm states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAG_ALM_NORMAL = 4'b0001,
    TAG_ALM_YELLOW = 4'b0010,
    TAG_ALM_IDLE = 4'b0100,
    TAG_ALM_AIS = 4'b1000
  } tag_alm_e;
endpackage : tag_pkg

// file: src/tag_pat_if.sv
// Interface: payload pattern request and answer
`timescale 1ns/1ps
`default_nettype none
interface tag_pat_if;
  logic bit_en;
  logic oh_bit;
  logic ais_bit;
  logic idle_bit;
  modport gen (input bit_en, input oh_bit, output ais_bit, output idle_bit);
  modport user (output bit_en, output oh_bit, input ais_bit, input idle_bit);
endinterface : tag_pat_if
`default_nettype wire

// file: src/tag_pat_gen.sv
// Payload pattern generator for DS3 AIS and IDLE
`timescale 1ns/1ps
`default_nettype none
module tag_pat_gen (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  tag_pat_if.gen pat
);
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;

  // ----------------------------------------
  // Phase restarts after each overhead bit
  // ----------------------------------------
  assign nxt_phase = pat.oh_bit ? 2'h0 : phase_ff + 2'h1;
  assign pat.ais_bit = ~phase_ff[0];
  assign pat.idle_bit = ~phase_ff[1];

  always_ff @(posedge mclk)
  begin
    if (srst)
      phase_ff <= 2'h0;
    else if (ce && pat.bit_en)
      phase_ff <= nxt_phase;
  end
endmodule : tag_pat_gen
`default_nettype wire

// file: tb/tag_liu_model.sv
// Line interface unit model at the far side of the transmit line
`timescale 1ns/1ps
`default_nettype none
module tag_liu_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic bit_taken,
  input wire logic line_pos_out,
  input wire logic line_neg_out,
  output logic rx_bit_ff,
  output logic neg_seen_ff
);
  // ----------------------------------------
  // Samples both rails one cycle after each bit
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rx_bit_ff <= 1'h0;
      neg_seen_ff <= 1'h0;
    end
    else if (bit_taken)
    begin
      rx_bit_ff <= line_pos_out;
      neg_seen_ff <= neg_seen_ff | line_neg_out;
    end
  end
endmodule : tag_liu_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the transmit alarm generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tag_pkg::*;
  typedef struct packed {
    logic [11:0] ctrl;
    tag_pos_t pos;
    logic d;
    logic [1:0] loss;
    logic ext;
    logic exp;
  } tag_row_s;
  logic mclk, srst, cyc, stb, we, ack, bit_en, dat, fs, sloss, floss, ferr, perr, berr, ext;
  logic pos_o, neg_o, bit_d, rx_bit, neg_seen;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  tag_pos_t pos;
  logic [2:0] sf;
  logic [1:0] gi;
  int errors, n_tests, cyc_cnt;
  tag_row_s rows [12];
  tag_alarm_gen dut (.mclk(mclk), .srst(srst), .ce(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_bit_en(bit_en),
    .tx_data(dat), .tx_pos(pos), .tx_frame_start(fs), .tx_subframe(sf), .tx_grp_idx(gi),
    .ext_overhead_in(ext), .signal_loss_flag(sloss), .frame_loss_flag(floss), .rx_frame_bit_error(ferr),
    .rx_path_parity_error(perr), .rx_bip8_error(berr), .line_pos_out(pos_o), .line_neg_out(neg_o));
  tag_liu_model liu (.mclk(mclk), .srst(srst), .bit_taken(bit_d), .line_pos_out(pos_o),
    .line_neg_out(neg_o), .rx_bit_ff(rx_bit), .neg_seen_ff(neg_seen));
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    bit_d <= bit_en;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000)
    begin
      errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge mclk); while (ack !== 1'h1);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  task automatic tx(input tag_pos_t p, input logic d, input logic f, input logic [2:0] s,
    input logic [1:0] g, input logic exp);
    @(posedge mclk);
    bit_en <= 1'h1;
    pos <= p;
    dat <= d;
    fs <= f;
    sf <= s;
    gi <= g;
    @(posedge mclk);
    bit_en <= 1'h0;
    fs <= 1'h0;
    @(posedge mclk);
    @(posedge mclk);
    chk({31'h0, rx_bit}, {31'h0, exp});
  endtask : tx
  task automatic err(input logic [2:0] m);
    @(posedge mclk);
    {ferr, perr, berr} <= m;
    @(posedge mclk);
    {ferr, perr, berr} <= 3'h0;
  endtask : err
  task automatic febe_grp(input logic [2:0] e);
    for (int k = 0; k < 3; k++)
      tx(TAG_POS_C, ~e[2-k], 1'h0, 3'h4, 2'(k), e[2-k]);
  endtask : febe_grp
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    {srst, cyc, stb, we, bit_en, dat, fs, sloss, floss, ferr, perr, berr, ext} = 13'h1000;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    pos = TAG_POS_PAY;
    sf = 3'h1;
    gi = 2'h0;
    rows[0] = {12'h00A, TAG_POS_ABIT, 1'h0, 2'h0, 1'h0, 1'h1};
    rows[1] = {12'h00B, TAG_POS_RDI, 1'h0, 2'h0, 1'h0, 1'h1};
    rows[2] = {12'h006, TAG_POS_PAY, 1'h0, 2'h0, 1'h0, 1'h1};
    rows[3] = {12'h007, TAG_POS_F, 1'h0, 2'h0, 1'h0, 1'h1};
    rows[4] = {12'h017, TAG_POS_PAY, 1'h1, 2'h0, 1'h0, 1'h0};
    rows[5] = {12'h143, TAG_POS_RDI, 1'h0, 2'h1, 1'h0, 1'h0};
    rows[6] = {12'h043, TAG_POS_RDI, 1'h0, 2'h1, 1'h0, 1'h1};
    rows[7] = {12'h042, TAG_POS_ABIT, 1'h0, 2'h2, 1'h0, 1'h1};
    rows[8] = {12'h042, TAG_POS_ABIT, 1'h1, 2'h0, 1'h0, 1'h0};
    rows[9] = {12'h082, TAG_POS_ABIT, 1'h0, 2'h0, 1'h1, 1'h1};
    rows[10] = {12'h010, TAG_POS_PAY, 1'h1, 2'h0, 1'h0, 1'h0};
    rows[11] = {12'h002, TAG_POS_PAY, 1'h1, 2'h0, 1'h0, 1'h1};
    repeat (4) @(posedge mclk);
    srst <= 1'h0;
    wb(1'h0, TAG_CTRL_OFS, 32'h0, 4'hF);
    chk(rd, {20'h0, TAG_CTRL_RST});
    wb(1'h0, 8'h08, 32'h0, 4'hF);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      ext <= rows[i].ext;
      {sloss, floss} <= rows[i].loss;
      wb(1'h1, TAG_CTRL_OFS, {20'h0, rows[i].ctrl}, 4'hF);
      repeat (3) @(posedge mclk);
      tx(rows[i].pos, rows[i].d, 1'h0, 3'h1, 2'h0, rows[i].exp);
    end
    {sloss, floss, ext} <= 3'h0;
    wb(1'h1, TAG_CTRL_OFS, 32'h4, 4'hF);
    tx(TAG_POS_X, 1'h1, 1'h0, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_X, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    wb(1'h1, TAG_CTRL_OFS, 32'h0, 4'hF);
    tx(TAG_POS_X, 1'h1, 1'h0, 3'h2, 2'h0, 1'h0);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_X, 1'h1, 1'h0, 3'h1, 2'h0, 1'h1);
    wb(1'h1, TAG_CTRL_OFS, 32'hC, 4'hF);
    tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, 1'h0);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h1);
    for (int k = 0; k < 4; k++)
      tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, ~k[0]);
    tx(TAG_POS_C, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    tx(TAG_POS_X, 1'h0, 1'h0, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, 1'h1);
    wb(1'h0, TAG_STAT_OFS, 32'h0, 4'hF);
    chk({28'h0, rd[3:0]}, 32'h8);
    wb(1'h1, TAG_CTRL_OFS, 32'h8, 4'hF);
    tx(TAG_POS_PAY, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h1);
    for (int k = 0; k < 4; k++)
      tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, ~k[1]);
    tx(TAG_POS_C, 1'h1, 1'h0, 3'h3, 2'h0, 1'h0);
    tx(TAG_POS_C, 1'h1, 1'h0, 3'h5, 2'h0, 1'h1);
    tx(TAG_POS_C, 1'h0, 1'h0, 3'h5, 2'h1, 1'h0);
    tx(TAG_POS_X, 1'h0, 1'h0, 3'h1, 2'h0, 1'h1);
    wb(1'h1, TAG_CTRL_OFS, 32'h0, 4'hF);
    tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, 1'h0);
    wb(1'h1, TAG_CTRL_OFS, 32'h401, 4'hF);
    febe_grp(3'h7);
    err(3'h4);
    febe_grp(3'h2);
    febe_grp(3'h7);
    floss <= 1'h1;
    err(3'h2);
    febe_grp(3'h2);
    floss <= 1'h0;
    wb(1'h1, TAG_CTRL_OFS, 32'h400, 4'hF);
    err(3'h4);
    tx(TAG_POS_C, 1'h1, 1'h0, 3'h4, 2'h0, 1'h1);
    ext <= 1'h1;
    wb(1'h1, TAG_CTRL_OFS, 32'h421, 4'hF);
    err(3'h4);
    tx(TAG_POS_C, 1'h1, 1'h0, 3'h4, 2'h0, 1'h1);
    ext <= 1'h0;
    wb(1'h1, TAG_CTRL_OFS, 32'h3, 4'hF);
    tx(TAG_POS_REI, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    err(3'h1);
    tx(TAG_POS_REI, 1'h0, 1'h0, 3'h1, 2'h0, 1'h1);
    tx(TAG_POS_REI, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    floss <= 1'h1;
    err(3'h1);
    tx(TAG_POS_REI, 1'h1, 1'h0, 3'h1, 2'h0, 1'h0);
    floss <= 1'h0;
    wb(1'h1, TAG_CTRL_OFS, 32'h1C, 4'hF);
    tx(TAG_POS_F, 1'h1, 1'h1, 3'h1, 2'h0, 1'h0);
    tx(TAG_POS_PAY, 1'h0, 1'h0, 3'h1, 2'h0, 1'h0);
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    wb(1'h0, TAG_CTRL_OFS, 32'h0, 4'hF);
    chk(rd, {20'h0, TAG_CTRL_RST});
    wb(1'h0, TAG_STAT_OFS, 32'h0, 4'hF);
    chk({28'h0, rd[3:0]}, 32'h1);
    wb(1'h1, TAG_CTRL_OFS, 32'h0000_0E00, 4'h2);
    wb(1'h0, TAG_CTRL_OFS, 32'h0, 4'hF);
    chk(rd, 32'hE00);
    chk({31'h0, neg_seen}, 32'h0);
    test_done();
  end
endmodule : testbench
`default_nettype wire
